// file: core/edge_watch.sv
// Edge-loss timer: counts reference cycles since the last edge of a synchronised clock
`timescale 1ns/1ps
`default_nettype none
module edge_watch
  import osc_pkg::*;
#(
  parameter int LIMIT = 8004
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic sig_in,
  output logic      fail
);

  logic        s1_reg;
  logic        s2_reg;
  logic        s3_reg;
  logic [31:0] cnt_reg;

  // Two-stage synchroniser; the edge detector compares stage two with stage three
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= sig_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 32'h0;
      fail    <= 1'b0;
    end else if (!enable || (s2_reg != s3_reg)) begin
      cnt_reg <= 32'h0;
      fail    <= 1'b0;
    end else if (cnt_reg >= 32'(LIMIT - 1)) begin
      fail    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
    end
  end

endmodule
`default_nettype wire

// file: core/osc_pkg.sv
// Constants and carrier types for the oscillator select and lock block
package osc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] OSC_CONTROL_ADDR = 12'h000;
  localparam logic [11:0] OSC_STATUS_ADDR  = 12'h004;
  localparam logic [7:0]  UNLOCK_FIRST     = 8'he7;
  localparam logic [7:0]  UNLOCK_SECOND    = 8'h18;

  // Control fields
  localparam int IPO_EN_BIT    = 7;
  localparam int XTAL_EN_BIT   = 6;
  localparam int WDOG_EN_BIT   = 5;
  localparam int SYS_OSC_FAIL_DETECT_EN_BIT     = 4;
  localparam int WDOG_OSC_FAIL_DETECT_EN_BIT     = 3;
  localparam int SEL_LSB       = 0;
  localparam logic [7:0] OSC_CONTROL_RESET = 8'ha0;

  // Clock source select codes
  typedef enum logic [2:0] {
    SRC_IPO_FAST = 3'b000,
    SRC_IPO_SLOW = 3'b001,
    SRC_CRYSTAL  = 3'b010,
    SRC_EXT_RC   = 3'b011,
    SRC_EXT_CLK  = 3'b100,
    SRC_WDOG     = 3'b101,
    SRC_RSVD6    = 3'b110,
    SRC_RSVD7    = 3'b111
  } clock_src_t;

  typedef struct packed {
    logic       ipo_en;
    logic       crystal_en;
    logic       wdog_en;
    logic       sys_osc_fail_detect_en;
    logic       wdog_osc_fail_detect_en;
    clock_src_t clock_source_select;
  } osc_control_t;

  typedef enum logic [1:0] {
    LK_LOCKED = 2'b00,
    LK_FIRST  = 2'b01,
    LK_OPEN   = 2'b10
  } lock_state_t;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ            = 25_000_000;
  localparam int WDOG_FAIL_CYCLES  = 8004;
  // Primary check: count of 25 MHz reference cycles per system clock period at 1 kHz (two edges)
  localparam int PRI_FAIL_HZ       = 1000;
  localparam int PRI_FAIL_CYCLES   = CLK_HZ / PRI_FAIL_HZ;

endpackage

// file: core/oscillator_select_lock.sv
// Oscillator control register with unlock sequence, source select and failure detection
`timescale 1ns/1ps
`default_nettype none
module oscillator_select_lock
  import osc_pkg::*;
#(
  parameter int WDOG_FAIL_LIMIT = WDOG_FAIL_CYCLES,
  parameter int PRI_FAIL_LIMIT  = PRI_FAIL_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        crystal_disable_option,
  input  wire logic [1:0]  ext_osc_mode_option,
  input  wire logic        primary_clk_mon,
  input  wire logic        wdog_clk_mon,
  output logic             ipo_enable,
  output logic             ipo_slow,
  output logic             crystal_enable,
  output logic [1:0]       crystal_mode,
  output logic             wdog_osc_enable,
  output logic [2:0]       clock_source_sel,
  output logic             sys_osc_fail_event,
  output logic             wdog_osc_fail_event
);

  // ****************************************
  // Bus decode
  // ****************************************
  osc_control_t osc_control_reg;
  lock_state_t  lock_reg;
  logic         sys_fail_flag_reg;
  logic         wdog_fail_flag_reg;
  logic         sys_fail_raw;
  logic         wdog_fail_raw;
  logic         sys_fail_d_reg;
  logic         wdog_fail_d_reg;
  logic         wr_ctl;
  logic         wr_sts;
  logic         setup;
  logic         mapped;
  logic [7:0]   wbyte;

  assign setup  = psel && !penable;
  assign mapped = (paddr == OSC_CONTROL_ADDR) || (paddr == OSC_STATUS_ADDR);
  assign wbyte  = pwdata[7:0];
  assign wr_ctl = psel && penable && pready && pwrite && (paddr == OSC_CONTROL_ADDR);
  assign wr_sts = psel && penable && pready && pwrite && (paddr == OSC_STATUS_ADDR);

  // No wait state: ready in the first access cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite) begin
        unique case (paddr)
          OSC_CONTROL_ADDR: prdata <= {24'h0, osc_control_reg};
          OSC_STATUS_ADDR:  prdata <= {28'h0, lock_reg, wdog_fail_flag_reg, sys_fail_flag_reg};
          default:          prdata <= 32'h0;
        endcase
      end else begin
        prdata <= 32'h0;
      end
    end
  end

  // ****************************************
  // Unlock tracker
  // ****************************************
  // Other addresses never touch the tracker
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lock_reg <= LK_LOCKED;
    end else if (wr_ctl) begin
      unique case (lock_reg)
        LK_LOCKED: lock_reg <= (wbyte == UNLOCK_FIRST) ? LK_FIRST : LK_LOCKED;
        LK_FIRST:  lock_reg <= (wbyte == UNLOCK_SECOND) ? LK_OPEN : LK_LOCKED;
        LK_OPEN:   lock_reg <= LK_LOCKED;
        default:   lock_reg <= LK_LOCKED;
      endcase
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  // Reset selects the fast internal oscillator, enabled
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      osc_control_reg <= osc_control_t'(OSC_CONTROL_RESET);
    end else if (sys_fail_raw && !sys_fail_d_reg && osc_control_reg.wdog_en) begin
      // Recovery overrides software; only the source moves
      osc_control_reg.clock_source_select <= SRC_WDOG;
    end else if (wr_ctl && lock_reg == LK_OPEN) begin
      // Whole byte, including the speed choice of the internal oscillator
      osc_control_reg <= osc_control_t'(wbyte);
    end
    // Any other write leaves contents alone
  end

  // ****************************************
  // Failure detection
  // ****************************************
  // Primary monitor loses edges below the threshold rate
  edge_watch #(.LIMIT(PRI_FAIL_LIMIT)) u_pri_watch (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .enable (osc_control_reg.sys_osc_fail_detect_en && !wdog_fail_flag_reg),
    .sig_in (primary_clk_mon),
    .fail   (sys_fail_raw)
  );

  // Watchdog edge loss over the fixed count
  edge_watch #(.LIMIT(WDOG_FAIL_LIMIT)) u_wdog_watch (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .enable (osc_control_reg.wdog_osc_fail_detect_en),
    .sig_in (wdog_clk_mon),
    .fail   (wdog_fail_raw)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sys_fail_d_reg  <= 1'b0;
      wdog_fail_d_reg <= 1'b0;
    end else begin
      sys_fail_d_reg  <= sys_fail_raw;
      wdog_fail_d_reg <= wdog_fail_raw;
    end
  end

  // Sticky flags; write one to clear, new event wins over the clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sys_fail_flag_reg  <= 1'b0;
      wdog_fail_flag_reg <= 1'b0;
    end else begin
      if (sys_fail_raw && !sys_fail_d_reg) begin
        sys_fail_flag_reg <= 1'b1;
      end else if (wr_sts && pwdata[0]) begin
        sys_fail_flag_reg <= 1'b0;
      end
      if (wdog_fail_raw && !wdog_fail_d_reg) begin
        wdog_fail_flag_reg <= 1'b1;
      end else if (wr_sts && pwdata[1]) begin
        wdog_fail_flag_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ipo_enable          <= 1'b1;
      ipo_slow            <= 1'b0;
      crystal_enable      <= 1'b0;
      crystal_mode        <= 2'b00;
      wdog_osc_enable     <= 1'b1;
      clock_source_sel    <= 3'b000;
      sys_osc_fail_event  <= 1'b0;
      wdog_osc_fail_event <= 1'b0;
    end else begin
      ipo_enable          <= osc_control_reg.ipo_en;
      ipo_slow            <= osc_control_reg.clock_source_select == SRC_IPO_SLOW;
      // Disable option low forces the crystal on, so no wait is needed
      crystal_enable      <= osc_control_reg.crystal_en || !crystal_disable_option;
      crystal_mode        <= ext_osc_mode_option;
      wdog_osc_enable     <= osc_control_reg.wdog_en;
      clock_source_sel    <= osc_control_reg.clock_source_select;
      sys_osc_fail_event  <= sys_fail_raw && !sys_fail_d_reg;
      wdog_osc_fail_event <= wdog_fail_raw && !wdog_fail_d_reg;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // Each step is checked on its own; the tracker holds progress across any gap without control register writes
  sequence unlock_first_s;
    wr_ctl && wbyte == UNLOCK_FIRST && lock_reg == LK_LOCKED;
  endsequence

  sequence unlock_second_s;
    wr_ctl && wbyte == UNLOCK_SECOND && lock_reg == LK_FIRST;
  endsequence

  sequence recover_hit_s;
    sys_fail_raw && !sys_fail_d_reg && osc_control_reg.wdog_en;
  endsequence

  first_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
    unlock_first_s |=> lock_reg == LK_FIRST) else $error("first unlock value not taken");

  unlock_opens_a: assert property (@(posedge mclk) disable iff (!rst_n)
    unlock_second_s |=> lock_reg == LK_OPEN) else $error("unlock pair did not open");

  ready_follows_a: assert property (@(posedge mclk) disable iff (!rst_n)
    setup |=> pready) else $error("no ready after setup");

  ready_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
    pready |=> !pready) else $error("ready held too long");

  err_unmapped_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (setup && !mapped) |=> pslverr) else $error("unmapped access not refused");

  err_mapped_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (setup && mapped) |=> !pslverr) else $error("mapped access refused");

  rdata_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !pready |-> prdata == 32'h0) else $error("read data outside access");

  ctl_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (setup && !pwrite && paddr == OSC_CONTROL_ADDR) |=> prdata[7:0] == $past(osc_control_reg))
    else $error("control read data wrong");

  ipo_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> ipo_enable == $past(osc_control_reg.ipo_en)) else $error("ipo enable output wrong");

  src_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> clock_source_sel == $past(osc_control_reg.clock_source_select))
    else $error("source select output wrong");

  crystal_force_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !crystal_disable_option |=> crystal_enable) else $error("crystal not forced on");

  mode_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> crystal_mode == $past(ext_osc_mode_option)) else $error("crystal mode not from option");

  sys_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sys_osc_fail_event |=> !sys_osc_fail_event) else $error("primary fail event not a pulse");

  sys_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (sys_fail_raw && !sys_fail_d_reg) |=> sys_fail_flag_reg) else $error("primary flag not set");

  wdog_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (wdog_fail_raw && !wdog_fail_d_reg) |=> wdog_fail_flag_reg) else $error("watchdog flag not set");

  no_recover_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (sys_fail_raw && !sys_fail_d_reg && !osc_control_reg.wdog_en && !(wr_ctl && lock_reg == LK_OPEN))
      |=> $stable(osc_control_reg.clock_source_select)) else $error("switch without watchdog oscillator");

  pri_blocked_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wdog_fail_flag_reg |=> !sys_fail_raw) else $error("primary detect after watchdog failure");

  wdog_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !osc_control_reg.wdog_osc_fail_detect_en |=> !wdog_fail_raw) else $error("watchdog detect while off");

  sys_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !osc_control_reg.sys_osc_fail_detect_en |=> !sys_fail_raw) else $error("primary detect while off");
  locked_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (lock_reg != LK_OPEN && !(sys_fail_raw && !sys_fail_d_reg)) |=> $stable(osc_control_reg))
    else $error("locked register changed");
  other_keeps_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (!wr_ctl) |=> $stable(lock_reg)) else $error("tracker moved without control write");
  open_relock_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_ctl && lock_reg == LK_OPEN) |=> lock_reg == LK_LOCKED && osc_control_reg.clock_source_select == $past(wbyte[2:0])
      || $past(sys_fail_raw && !sys_fail_d_reg)) else $error("open write did not take and relock");
  bad_value_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_ctl && lock_reg == LK_FIRST && wbyte != UNLOCK_SECOND) |=> lock_reg == LK_LOCKED)
    else $error("tracker not reset by wrong value");
  ipo_kept_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ($changed(osc_control_reg.clock_source_select) && !$past(wr_ctl)) |-> osc_control_reg.ipo_en == $past(osc_control_reg.ipo_en))
    else $error("ipo enable changed by recovery");
  recover_a: assert property (@(posedge mclk) disable iff (!rst_n)
    recover_hit_s |=> (osc_control_reg.clock_source_select == SRC_WDOG && sys_osc_fail_event))
    else $error("no recovery to watchdog oscillator");
  event_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wdog_osc_fail_event |=> !wdog_osc_fail_event) else $error("watchdog fail event not a pulse");
  slow_map_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (osc_control_reg.clock_source_select == SRC_IPO_SLOW) |=> ipo_slow) else $error("slow speed not driven");

endmodule
`default_nettype wire

// file: sim/tb_oscillator_select_lock.sv
// Self-checking testbench for the oscillator select and lock block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_oscillator_select_lock
  import osc_pkg::*;
;
  localparam int WDOG_LIM = 20;
  localparam int PRI_LIM  = 30;
  localparam logic [11:0] BAD_ADDR = 12'h100;

  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        xtal_off = 1'b1;
  logic [1:0]  mode_opt = 2'b00;
  logic        pri_mon = 1'b0;
  logic        wd_mon = 1'b0;
  logic        pri_run = 1'b1;
  logic        wd_run = 1'b1;
  logic        ipo_enable;
  logic        ipo_slow;
  logic        crystal_enable;
  logic [1:0]  crystal_mode;
  logic        wdog_osc_enable;
  logic [2:0]  clock_source_sel;
  logic        sys_osc_fail_event;
  logic        wdog_osc_fail_event;
  int          err_count = 0;
  int          n_checks = 0;
  logic [31:0] rdat;
  logic        rerr;
  int          n;

  oscillator_select_lock #(.WDOG_FAIL_LIMIT(WDOG_LIM), .PRI_FAIL_LIMIT(PRI_LIM)) uut (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crystal_disable_option(xtal_off), .ext_osc_mode_option(mode_opt),
    .primary_clk_mon(pri_mon), .wdog_clk_mon(wd_mon), .ipo_enable(ipo_enable),
    .ipo_slow(ipo_slow), .crystal_enable(crystal_enable), .crystal_mode(crystal_mode),
    .wdog_osc_enable(wdog_osc_enable), .clock_source_sel(clock_source_sel),
    .sys_osc_fail_event(sys_osc_fail_event), .wdog_osc_fail_event(wdog_osc_fail_event));

  always #20 mclk = ~mclk;

  // Monitor clocks only toggle while their oscillator is meant to be alive
  always @(posedge mclk) begin
    if (pri_run) pri_mon <= ~pri_mon;
    if (wd_run) wd_mon <= ~wd_mon;
  end

  // ****************************************
  // Bus tasks
  // ****************************************
  // Ready and data are taken at the rising edge itself, before that edge's updates land
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin @(posedge mclk); k++; end while (pready !== 1'b1 && k < 50);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) err_count++;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(nm, {24'h000000, e}, rdat)
  endtask

  task automatic unlock_wr(input logic [7:0] v);
    wr(OSC_CONTROL_ADDR, UNLOCK_FIRST);
    wr(OSC_CONTROL_ADDR, UNLOCK_SECOND);
    wr(OSC_CONTROL_ADDR, v);
    repeat (2) @(negedge mclk);
  endtask

  // Bounded wait for a one-cycle pulse, n holds the cycles taken
  task automatic wait_pulse(ref logic p);
    n = 0;
    do begin @(negedge mclk); n++; end while (p !== 1'b1 && n < 200);
  endtask

  task automatic summarize();
    if (err_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    `CHK("ipo_enable", 1'b1, ipo_enable)
    `CHK("clock_source_sel", 3'h0, clock_source_sel)
    rd_chk(OSC_CONTROL_ADDR, OSC_CONTROL_RESET, "control");
    wr(OSC_CONTROL_ADDR, 8'h55);
    rd_chk(OSC_CONTROL_ADDR, OSC_CONTROL_RESET, "control");
    wr(OSC_CONTROL_ADDR, UNLOCK_SECOND);
    wr(OSC_CONTROL_ADDR, UNLOCK_FIRST);
    wr(OSC_CONTROL_ADDR, 8'h55);
    rd_chk(OSC_CONTROL_ADDR, OSC_CONTROL_RESET, "control");
    // Other traffic between the two unlock values keeps the progress
    wr(OSC_CONTROL_ADDR, UNLOCK_FIRST);
    rd_chk(OSC_STATUS_ADDR, 8'h04, "status");
    wr(BAD_ADDR, 8'hff);
    `CHK("pslverr", 1'b1, rerr)
    rd_chk(BAD_ADDR, 8'h00, "unmapped");
    wr(OSC_CONTROL_ADDR, UNLOCK_SECOND);
    rd_chk(OSC_STATUS_ADDR, 8'h08, "status");
    wr(OSC_CONTROL_ADDR, 8'ha1);
    rd_chk(OSC_CONTROL_ADDR, 8'ha1, "control");
    rd_chk(OSC_STATUS_ADDR, 8'h00, "status");
    wr(OSC_CONTROL_ADDR, 8'h00);
    rd_chk(OSC_CONTROL_ADDR, 8'ha1, "control");
    // A wrong middle value, or the first value twice, restarts the sequence
    for (int i = 0; i < 2; i++) begin
      wr(OSC_CONTROL_ADDR, UNLOCK_FIRST);
      wr(OSC_CONTROL_ADDR, i == 0 ? 8'h33 : UNLOCK_FIRST);
      wr(OSC_CONTROL_ADDR, UNLOCK_SECOND);
      wr(OSC_CONTROL_ADDR, 8'ha0);
      rd_chk(OSC_CONTROL_ADDR, 8'ha1, "control");
    end
    // Source select codes 0 to 5, fail detectors off, oscillators enabled in the same write
    for (int s = 0; s < 6; s++) begin
      unlock_wr(8'he0 | 8'(s));
      `CHK("clock_source_sel", 3'(s), clock_source_sel)
      `CHK("ipo_enable", 1'b1, ipo_enable)
      `CHK("ipo_slow", s == 1, ipo_slow)
      `CHK("crystal_enable", 1'b1, crystal_enable)
    end
    unlock_wr(8'h20);
    `CHK("ipo_enable", 1'b0, ipo_enable)
    `CHK("crystal_enable", 1'b0, crystal_enable)
    @(posedge mclk);
    xtal_off <= 1'b0;
    repeat (2) @(negedge mclk);
    `CHK("crystal_enable", 1'b1, crystal_enable)
    for (int m = 0; m < 4; m++) begin
      @(posedge mclk);
      mode_opt <= 2'(m);
      repeat (3) @(negedge mclk);
      `CHK("crystal_mode", 2'(m), crystal_mode)
    end
    // Watchdog monitor stops: failure only after the full count
    unlock_wr(8'ha8);
    @(posedge mclk);
    wd_run <= 1'b0;
    wait_pulse(wdog_osc_fail_event);
    `CHK("wdog_fail_late", 1'b1, n >= WDOG_LIM && n < 200)
    @(posedge mclk);
    wd_run <= 1'b1;
    rd_chk(OSC_STATUS_ADDR, 8'h02, "status");
    wr(OSC_STATUS_ADDR, 8'h03);
    rd_chk(OSC_STATUS_ADDR, 8'h00, "status");
    // Primary monitor stops: recovery moves to the watchdog oscillator
    unlock_wr(8'hb0);
    @(posedge mclk);
    pri_run <= 1'b0;
    wait_pulse(sys_osc_fail_event);
    `CHK("pri_fail_late", 1'b1, n >= PRI_LIM && n < 200)
    repeat (3) @(negedge mclk);
    `CHK("clock_source_sel", SRC_WDOG, clock_source_sel)
    rd_chk(OSC_CONTROL_ADDR, 8'hb5, "control");
    rd_chk(OSC_STATUS_ADDR, 8'h01, "status");
    summarize();
  end

  initial begin
    #400000;
    err_count++;
    summarize();
  end
endmodule
`default_nettype wire
